// >>> ppt_pkg.sv
// Purpose: Constants and types for the parallel port block
// Assumes: 16-bit registers on a plain register port
// Notes:   Offsets are word indices on the register port
package ppt_pkg;
	localparam logic [2:0]  ADDR_CONTROL  = 3'h0;
	localparam logic [2:0]  ADDR_MODE     = 3'h1;
	localparam logic [2:0]  ADDR_ADDRESS  = 3'h2;
	localparam logic [2:0]  ADDR_PIN_EN   = 3'h3;
	localparam logic [2:0]  ADDR_STATUS   = 3'h4;
	localparam logic [2:0]  ADDR_PADCFG   = 3'h5;
	localparam logic [2:0]  ADDR_DATA     = 3'h6;
	localparam logic [15:0] CONTROL_MASK  = 16'hBFEF;
	localparam logic [15:0] PIN_EN_MASK   = 16'h47FF;
	localparam logic [15:0] PADCFG_MASK   = 16'h0001;
	localparam logic [15:0] RESET_ZERO    = 16'h0000;
	localparam int          BIT_ENABLE    = 15;
	localparam int          BIT_CSF_HI    = 7;
	localparam int          BIT_ALP       = 5;
	localparam int          BIT_CHIP_SELECT_POLARITY      = 3;
	localparam int          BIT_BEP       = 2;
	localparam int          BIT_WRITE_STROBE_POLARITY      = 1;
	localparam int          BIT_READ_STROBE_POLARITY      = 0;
	localparam int          BIT_CS_ADDR   = 14;
	localparam int          BIT_ADDR_TOP  = 15;
	localparam int          ADDR_LINES    = 11;
	localparam int          DATA_W        = 8;
	localparam int          SLOTS         = 4;
	localparam logic [1:0]  MODE_SLAVE    = 2'h0;
	localparam logic [1:0]  MODE_ESLAVE   = 2'h1;
	localparam logic [1:0]  MODE_MASTER2  = 2'h2;
	localparam logic [1:0]  MODE_MASTER1  = 2'h3;
	localparam logic [1:0]  STEP_UP       = 2'h1;
	localparam logic [1:0]  STEP_DOWN     = 2'h2;
	localparam logic [1:0]  MUX_NONE      = 2'h0;
	localparam logic [3:0]  WAIT_NONE     = 4'h0;
	localparam logic [3:0]  ONE_CYCLE     = 4'h1;
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_ADDR   = 3'b001,
		ST_SETUP  = 3'b010,
		ST_STROBE = 3'b011,
		ST_HOLD   = 3'b100
	} ppt_state_type;
endpackage

// >>> ppt_slot_if.sv
// Purpose: Carrier between the port core and the slave buffer
// Assumes: One clock domain
// Notes:   Core drives requests, buffer answers status
`timescale 1ns/1ps
`default_nettype none
interface ppt_slot_if;
	logic       ext_write;
	logic       ext_read;
	logic [1:0] ext_slot;
	logic [7:0] ext_wdata;
	logic [7:0] ext_rdata;
	logic       sw_read;
	logic       sw_write;
	logic [1:0] sw_slot;
	logic [7:0] sw_wdata;
	logic [7:0] sw_rdata;
	logic       clr_ov;
	logic       clr_uf;
	logic [3:0] in_full;
	logic [3:0] out_empty;
	logic       overflow;
	logic       underflow;
	modport core (output ext_write, ext_read, ext_slot, ext_wdata, sw_read, sw_write,
		sw_slot, sw_wdata, clr_ov, clr_uf,
		input ext_rdata, sw_rdata, in_full, out_empty, overflow, underflow);
	modport buffer (input ext_write, ext_read, ext_slot, ext_wdata, sw_read, sw_write,
		sw_slot, sw_wdata, clr_ov, clr_uf,
		output ext_rdata, sw_rdata, in_full, out_empty, overflow, underflow);
endinterface
`default_nettype wire

// >>> ppt_slot_buffer.sv
// Purpose: Four-byte input and output buffers for slave operation
// Assumes: Requests are one-cycle pulses
// Notes:   Hardware set wins over software clear, except output-empty, where a software write wins over an external read
`timescale 1ns/1ps
`default_nettype none
module ppt_slot_buffer (
	input  wire logic clock_in, // System clock
	input  wire logic rst_in,   // Synchronous reset
	ppt_slot_if.buffer sl       // Core side
);
	logic [7:0] in_ff  [4];
	logic [7:0] out_ff [4];
	logic [3:0] full_ff;
	logic [3:0] empty_ff;
	logic       ov_ff;
	logic       uf_ff;
	logic [7:0] ext_rd_ff;
	logic [7:0] sw_rd_ff;

	wire ov_hit = sl.ext_write && full_ff[sl.ext_slot];
	wire uf_hit = sl.ext_read && empty_ff[sl.ext_slot];

	genvar g;
	generate
		for (g = 0; g < ppt_pkg::SLOTS; g++) begin : g_slot
			always_ff @(posedge clock_in) begin
				if (rst_in) begin
					in_ff[g]    <= 8'h00;
					out_ff[g]   <= 8'h00;
					full_ff[g]  <= 1'b0;
					empty_ff[g] <= 1'b1;
				end else begin
					if (sl.ext_write && sl.ext_slot == g && !full_ff[g]) begin
						in_ff[g]   <= sl.ext_wdata;
						full_ff[g] <= 1'b1;
					end else if (sl.sw_read && sl.sw_slot == g) begin
						full_ff[g] <= 1'b0;
					end
					if (sl.sw_write && sl.sw_slot == g) begin
						out_ff[g]   <= sl.sw_wdata;
						empty_ff[g] <= 1'b0;
					end else if (sl.ext_read && sl.ext_slot == g) begin
						empty_ff[g] <= 1'b1;
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			ov_ff     <= 1'b0;
			uf_ff     <= 1'b0;
			ext_rd_ff <= 8'h00;
			sw_rd_ff  <= 8'h00;
		end else begin
			ov_ff     <= ov_hit | (ov_ff & ~sl.clr_ov);
			uf_ff     <= uf_hit | (uf_ff & ~sl.clr_uf);
			ext_rd_ff <= out_ff[sl.ext_slot];
			sw_rd_ff  <= in_ff[sl.sw_slot];
		end
	end

	assign sl.in_full   = full_ff;
	assign sl.out_empty = empty_ff;
	assign sl.overflow  = ov_ff;
	assign sl.underflow = uf_ff;
	assign sl.ext_rdata = ext_rd_ff;
	assign sl.sw_rdata  = sw_rd_ff;
endmodule
`default_nettype wire

// >>> ppt_port.sv
// Purpose: Configurable 8-bit parallel master and slave port
// Assumes: Register port reads answer one cycle later; one Tcy is one clock
// Notes:   Master transfers start by writing or reading the data register
// What this block does
// - Data moves over an 8-bit parallel bus.
// - Up to 11 address lines with chip select, 12 without.
// - Enhanced slave has address support and a four-byte buffer; plain slave mode auto-increments the slot.
// - Outside master mode 1, write polarity bit sets write strobe level.
// - In master mode 1, that bit sets enable strobe level.
// - Outside master mode 1, read polarity bit sets read strobe level.
// - Latch and chip-select polarity ignored when pins carry address.
// - Data setup wait of 1 to 4 cycles; same for multiplexed address phase.
// - Strobe wait of zero skips the data setup and hold waits; the multiplexed address phase still uses the setup wait.
// - Address bit 14 drives chip select one, one means active.
// - Address bits 13-0 are the destination address; bit 15 is stored but drives no pin.
// - Pin-enable 14 gives pin to address 14 or chip select, else I/O.
// - Two lowest pin-enables give address 1:0 or latch strobes, else I/O.
// - Input-all-full reads one only when all input slots are full.
// - External write into a full slot sets sticky overflow until software clears.
// - Each input slot flag shows unread data; reading the slot clears it.
// - Output-all-empty reads one only when all output slots empty; resets one.
// - External read of an empty slot sets sticky underflow until cleared.
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module ppt_port (
	input  wire logic        clock_in,       // 100 MHz clock
	input  wire logic        rst_in,         // Synchronous reset
	input  wire logic [2:0]  reg_addr_in,    // Register index
	input  wire logic [15:0] reg_wdata_in,   // Register write data
	input  wire logic        reg_write_in,   // Write strobe
	input  wire logic        reg_read_in,    // Read strobe
	output logic      [15:0] reg_rdata_out,  // Read data, cycle after strobe
	input  wire logic [7:0]  data_pins_in,   // Data pins in
	output logic      [7:0]  data_pins_out,  // Data pins out
	output logic             data_pins_oe_n_out, // Low while driving data
	output logic      [15:0] address_pins_out,   // Address pins, bit 14 shared
	output logic      [15:0] address_pin_func_out, // One where pin is port-owned
	output logic             write_strobe_pin_out, // Write or enable strobe
	output logic             read_strobe_pin_out,  // Read or read/write strobe
	output logic             byte_enable_pin_out,  // Byte enable
	input  wire logic        ext_write_in,   // Slave: external write strobe
	input  wire logic        ext_read_in,    // Slave: external read strobe
	input  wire logic        ext_cs_in,      // Slave: external chip select
	input  wire logic [1:0]  ext_addr_in,    // Slave: external address
	output logic             busy_out,       // Master transfer in progress
	output logic             ttl_select_out  // Input buffer type select
);
	logic [15:0] ctl_ff, mode_ff, addr_ff, pen_ff, pad_ff;
	logic [7:0]  dout_ff, din_ff;
	logic [3:0]  cnt_ff, nxt_cnt;
	logic        is_read_ff, busy_ff, rd_pend_ff, ext_wr_ff, ext_rd_ff;
	logic [1:0]  auto_ff;
	logic [2:0]  rd_sel_ff;
	ppt_pkg::ppt_state_type st_ff, nxt_st;

	ppt_slot_if sl ();
	ppt_slot_buffer u_buf (
		.clock_in (clock_in),
		.rst_in   (rst_in),
		.sl       (sl.buffer)
	);

	function automatic logic hit(input logic en, input logic [2:0] a, input logic [2:0] t);
		return en && (a == t);
	endfunction

	wire        enabled  = ctl_ff[ppt_pkg::BIT_ENABLE];
	wire [1:0]  mux      = ctl_ff[12:11];
	wire [1:0]  mode     = mode_ff[9:8];
	wire [1:0]  step     = mode_ff[12:11];
	wire [1:0]  w_setup  = mode_ff[7:6];
	wire [3:0]  w_strobe = mode_ff[5:2];
	wire [1:0]  w_hold   = mode_ff[1:0];
	wire        master   = mode[1];
	wire        wr_reg   = hit(reg_write_in, reg_addr_in, ppt_pkg::ADDR_DATA);
	wire        rd_reg   = hit(reg_read_in, reg_addr_in, ppt_pkg::ADDR_DATA);
	wire        start    = enabled && master && !busy_ff && (wr_reg || rd_reg);
	wire        waits_on = (w_strobe != ppt_pkg::WAIT_NONE);
	wire [3:0]  setup_n  = {2'b00, w_setup} + ppt_pkg::ONE_CYCLE;
	wire [3:0]  hold_n   = {2'b00, w_hold} + ppt_pkg::ONE_CYCLE;
	wire        cs_pins  = ctl_ff[ppt_pkg::BIT_CSF_HI]; // Pin 14 is chip select
	wire [15:0] status;
	wire        slave_on = enabled && !master;
	wire [1:0]  slave_sl = (mode == ppt_pkg::MODE_ESLAVE) ? ext_addr_in : auto_ff;

	// State machine for master cycles
	always_comb begin
		nxt_st  = st_ff;
		nxt_cnt = cnt_ff;
		case (st_ff)
			ppt_pkg::ST_IDLE: begin
				if (start) begin
					nxt_st  = (mux != ppt_pkg::MUX_NONE) ? ppt_pkg::ST_ADDR
						: (waits_on ? ppt_pkg::ST_SETUP : ppt_pkg::ST_STROBE);
					nxt_cnt = (mux != ppt_pkg::MUX_NONE || waits_on) ? setup_n : w_strobe;
				end
			end
			ppt_pkg::ST_ADDR: begin
				nxt_cnt = cnt_ff - ppt_pkg::ONE_CYCLE;
				if (cnt_ff == ppt_pkg::ONE_CYCLE) begin
					nxt_st  = waits_on ? ppt_pkg::ST_SETUP : ppt_pkg::ST_STROBE;
					nxt_cnt = waits_on ? setup_n : w_strobe;
				end
			end
			ppt_pkg::ST_SETUP: begin
				nxt_cnt = cnt_ff - ppt_pkg::ONE_CYCLE;
				if (cnt_ff == ppt_pkg::ONE_CYCLE) begin
					nxt_st  = ppt_pkg::ST_STROBE;
					nxt_cnt = w_strobe;
				end
			end
			ppt_pkg::ST_STROBE: begin
				nxt_cnt = cnt_ff - ppt_pkg::ONE_CYCLE;
				if (cnt_ff == ppt_pkg::WAIT_NONE) begin
					nxt_st  = waits_on ? ppt_pkg::ST_HOLD : ppt_pkg::ST_IDLE;
					nxt_cnt = hold_n;
				end
			end
			ppt_pkg::ST_HOLD: begin
				nxt_cnt = cnt_ff - ppt_pkg::ONE_CYCLE;
				if (cnt_ff == ppt_pkg::ONE_CYCLE)
					nxt_st = ppt_pkg::ST_IDLE;
			end
			default: begin
				nxt_st = ppt_pkg::ST_IDLE;
			end
		endcase
		if (!enabled)
			nxt_st = ppt_pkg::ST_IDLE;
	end

	wire done = (st_ff != ppt_pkg::ST_IDLE) && (nxt_st == ppt_pkg::ST_IDLE) && enabled;
	wire [13:0] addr_up = addr_ff[13:0] + 14'h0001;
	wire [13:0] addr_dn = addr_ff[13:0] - 14'h0001;

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			st_ff      <= ppt_pkg::ST_IDLE;
			cnt_ff     <= ppt_pkg::WAIT_NONE;
			busy_ff    <= 1'b0;
			is_read_ff <= 1'b0;
		end else begin
			st_ff   <= nxt_st;
			cnt_ff  <= nxt_cnt;
			busy_ff <= (nxt_st != ppt_pkg::ST_IDLE);
			if (start)
				is_read_ff <= rd_reg;
		end
	end

	// Registers; data register kept apart so reads do not disturb config
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			ctl_ff  <= ppt_pkg::RESET_ZERO;
			mode_ff <= ppt_pkg::RESET_ZERO;
			addr_ff <= ppt_pkg::RESET_ZERO;
			pen_ff  <= ppt_pkg::RESET_ZERO;
			pad_ff  <= ppt_pkg::RESET_ZERO;
		end else begin
			if (hit(reg_write_in, reg_addr_in, ppt_pkg::ADDR_CONTROL))
				ctl_ff <= reg_wdata_in & ppt_pkg::CONTROL_MASK;
			if (hit(reg_write_in, reg_addr_in, ppt_pkg::ADDR_MODE))
				mode_ff[14:0] <= reg_wdata_in[14:0];
			if (hit(reg_write_in, reg_addr_in, ppt_pkg::ADDR_PIN_EN))
				pen_ff <= reg_wdata_in & ppt_pkg::PIN_EN_MASK;
			if (hit(reg_write_in, reg_addr_in, ppt_pkg::ADDR_PADCFG))
				pad_ff <= reg_wdata_in & ppt_pkg::PADCFG_MASK;
			if (hit(reg_write_in, reg_addr_in, ppt_pkg::ADDR_ADDRESS))
				addr_ff <= reg_wdata_in;
			else if (done && step == ppt_pkg::STEP_UP)
				addr_ff[13:0] <= addr_up;
			else if (done && step == ppt_pkg::STEP_DOWN)
				addr_ff[13:0] <= addr_dn;
			mode_ff[15] <= 1'b0;
		end
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			dout_ff    <= 8'h00;
			din_ff     <= 8'h00;
			rd_pend_ff <= 1'b0;
			rd_sel_ff  <= 3'h0;
			auto_ff    <= 2'h0;
			ext_wr_ff  <= 1'b0;
			ext_rd_ff  <= 1'b0;
		end else begin
			if (start && wr_reg)
				dout_ff <= reg_wdata_in[7:0];
			if (done && is_read_ff)
				din_ff <= data_pins_in;
			rd_pend_ff <= reg_read_in;
			rd_sel_ff  <= reg_addr_in;
			ext_wr_ff  <= ext_write_in && ext_cs_in;
			ext_rd_ff  <= ext_read_in && ext_cs_in;
			if (slave_on && (ext_wr_ff || ext_rd_ff) && mode == ppt_pkg::MODE_SLAVE)
				auto_ff <= auto_ff + 2'h1;
		end
	end

	// External strobes taken on their first cycle only
	wire ext_wr_edge = ext_write_in && ext_cs_in && !ext_wr_ff && slave_on;
	wire ext_rd_edge = ext_read_in && ext_cs_in && !ext_rd_ff && slave_on;

	assign sl.ext_write = ext_wr_edge;
	assign sl.ext_read  = ext_rd_edge;
	assign sl.ext_slot  = slave_sl;
	assign sl.ext_wdata = data_pins_in;
	assign sl.sw_read   = rd_reg && !master;
	assign sl.sw_write  = wr_reg && !master;
	assign sl.sw_slot   = addr_ff[1:0];
	assign sl.sw_wdata  = reg_wdata_in[7:0];
	assign sl.clr_ov    = hit(reg_write_in, reg_addr_in, ppt_pkg::ADDR_STATUS)
		&& !reg_wdata_in[14];
	assign sl.clr_uf    = hit(reg_write_in, reg_addr_in, ppt_pkg::ADDR_STATUS)
		&& !reg_wdata_in[6];

	assign status = {&sl.in_full, sl.overflow, 2'b00, sl.in_full,
		&sl.out_empty, sl.underflow, 2'b00, sl.out_empty};

	// Strobes: active level per polarity bits
	wire in_strobe = (st_ff == ppt_pkg::ST_STROBE) && enabled;
	wire in_cycle  = (st_ff != ppt_pkg::ST_IDLE) && enabled;
	wire m1        = (mode == ppt_pkg::MODE_MASTER1);
	wire wr_act    = m1 ? in_strobe : (in_strobe && !is_read_ff);
	wire rd_act    = m1 ? (in_cycle && is_read_ff) : (in_strobe && is_read_ff);
	wire latch_on  = (st_ff == ppt_pkg::ST_ADDR) && enabled;
	wire address_latch_polarity       = ctl_ff[ppt_pkg::BIT_ALP];
	wire cs_lvl    = addr_ff[ppt_pkg::BIT_CS_ADDR] ~^ ctl_ff[ppt_pkg::BIT_CHIP_SELECT_POLARITY];
	wire [15:0] addr_vis;
	wire [15:0] pin_func;

	assign write_strobe_pin_out = enabled && ctl_ff[9]
		? (wr_act ~^ ctl_ff[ppt_pkg::BIT_WRITE_STROBE_POLARITY]) : 1'b0;
	assign read_strobe_pin_out  = enabled && ctl_ff[8]
		? (rd_act ~^ ctl_ff[ppt_pkg::BIT_READ_STROBE_POLARITY]) : 1'b0;
	assign byte_enable_pin_out  = enabled && ctl_ff[10]
		? (in_cycle ~^ ctl_ff[ppt_pkg::BIT_BEP]) : 1'b0;

	genvar p;
	generate
		for (p = 2; p < ppt_pkg::ADDR_LINES; p++) begin : g_apin
			assign pin_func[p] = pen_ff[p] && enabled;
			assign addr_vis[p] = pin_func[p] && addr_ff[p];
		end
		for (p = 0; p < 2; p++) begin : g_lpin
			assign pin_func[p] = pen_ff[p] && enabled;
			// Latch polarity only matters when muxing address here
			assign addr_vis[p] = !pin_func[p] ? 1'b0
				: (mux != ppt_pkg::MUX_NONE) ? (latch_on ~^ address_latch_polarity) : addr_ff[p];
		end
	endgenerate

	// Pin 14 is chip select or address; polarity ignored as address
	assign pin_func[14] = pen_ff[14] && enabled;
	assign addr_vis[14] = pin_func[14] && (cs_pins ? cs_lvl : addr_ff[14]);
	assign pin_func[15] = 1'b0;
	assign addr_vis[15] = 1'b0;
	assign pin_func[13:11] = 3'b000;
	assign addr_vis[13:11] = 3'b000;

	assign address_pins_out     = addr_vis;
	assign address_pin_func_out = pin_func;
	assign data_pins_out        = dout_ff;
	assign data_pins_oe_n_out   = !(in_cycle && !is_read_ff);
	assign busy_out             = busy_ff;
	assign ttl_select_out       = pad_ff[0];

	// Read data: one cycle after strobe, unmapped reads zero
	always_comb begin
		case (rd_sel_ff)
			ppt_pkg::ADDR_CONTROL: reg_rdata_out = ctl_ff;
			ppt_pkg::ADDR_MODE:    reg_rdata_out = {busy_ff, mode_ff[14:0]};
			ppt_pkg::ADDR_ADDRESS: reg_rdata_out = addr_ff;
			ppt_pkg::ADDR_PIN_EN:  reg_rdata_out = pen_ff;
			ppt_pkg::ADDR_STATUS:  reg_rdata_out = status;
			ppt_pkg::ADDR_PADCFG:  reg_rdata_out = pad_ff;
			ppt_pkg::ADDR_DATA:    reg_rdata_out = {8'h00, master ? din_ff : sl.sw_rdata};
			default:               reg_rdata_out = 16'h0000;
		endcase
		if (!rd_pend_ff)
			reg_rdata_out = 16'h0000;
	end
endmodule
`default_nettype wire

// >>> ppt_peer_model.sv
// Purpose: Far-side party of the parallel port: external master and peripheral
// Assumes: One clock; external strobes are one-cycle levels, active high
// Notes:   Released data lines show a changing pattern, never the last value
`timescale 1ns/1ps
`default_nettype none
module ppt_peer_model (
	input  wire logic       clock_in,     // Clock
	input  wire logic       rd_strobe_in, // Port read strobe pin
	input  wire logic       rd_pol_in,    // Read strobe active level
	input  wire logic [7:0] reply_in,     // Byte returned to a master read
	output logic      [7:0] data_out,     // Data lines toward the port
	output logic            wr_out,       // External write strobe
	output logic            rd_out,       // External read strobe
	output logic            cs_out,       // External chip select
	output logic      [1:0] slot_out      // External slot address
);
	logic [7:0] idle_ff = 8'h5A;
	logic [7:0] wdata_ff = 8'h00;
	logic       answer;
	// No pull on the data lines, so an idle bus keeps moving
	assign answer = rd_strobe_in === rd_pol_in;
	assign data_out = wr_out ? wdata_ff : (answer ? reply_in : idle_ff);
	// Plain always: the pattern register also carries a declaration initialiser
	always @(posedge clock_in) idle_ff <= idle_ff + 8'h35;
	initial begin
		wr_out = 1'b0;
		rd_out = 1'b0;
		cs_out = 1'b0;
		slot_out = 2'h0;
	end
	task automatic access(input logic wr, input logic [1:0] slot, input logic [7:0] d);
		@(posedge clock_in);
		cs_out <= 1'b1;
		wr_out <= wr;
		rd_out <= !wr;
		slot_out <= slot;
		wdata_ff <= d;
		@(posedge clock_in);
		cs_out <= 1'b0;
		wr_out <= 1'b0;
		rd_out <= 1'b0;
		slot_out <= ~slot;
	endtask
endmodule
`default_nettype wire

// >>> ppt_port_monitor.sv
// Purpose: Port-level checker for the parallel port
// Assumes: Register shadows rebuilt from the register port
// Notes:   Bound to every ppt_port instance
`timescale 1ns/1ps
`default_nettype none
module ppt_port_monitor (
	input wire logic        clock_in,             // Clock
	input wire logic        rst_in,               // Reset
	input wire logic [2:0]  reg_addr_in,          // Index
	input wire logic [15:0] reg_wdata_in,         // Write data
	input wire logic        reg_write_in,         // Write strobe
	input wire logic        reg_read_in,          // Read strobe
	input wire logic [15:0] reg_rdata_out,        // Read data
	input wire logic        data_pins_oe_n_out,   // Data enable
	input wire logic [15:0] address_pins_out,     // Address pins
	input wire logic [15:0] address_pin_func_out, // Pin owner
	input wire logic        write_strobe_pin_out, // Write strobe
	input wire logic        read_strobe_pin_out,  // Read strobe
	input wire logic        byte_enable_pin_out,  // Byte enable
	input wire logic        busy_out              // Busy
);
	logic [15:0] ctl_ff, mode_ff, pen_ff;
	logic        st_q_ff;
	logic        mst, start;
	assign mst = ctl_ff[15] && mode_ff[9];
	assign start = reg_write_in && reg_addr_in == ppt_pkg::ADDR_DATA;
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			ctl_ff <= 16'h0000;
			mode_ff <= 16'h0000;
			pen_ff <= 16'h0000;
		end else if (reg_write_in) begin
			if (reg_addr_in == ppt_pkg::ADDR_CONTROL) ctl_ff <= reg_wdata_in;
			if (reg_addr_in == ppt_pkg::ADDR_MODE) mode_ff <= reg_wdata_in;
			if (reg_addr_in == ppt_pkg::ADDR_PIN_EN) pen_ff <= reg_wdata_in;
		end
	end
	always_ff @(posedge clock_in) begin
		st_q_ff <= !rst_in && reg_read_in && reg_addr_in == ppt_pkg::ADDR_STATUS;
	end
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (rst_in);
	quiet_off_a: assert property (!ctl_ff[15] && !$past(ctl_ff[15]) |->
		!write_strobe_pin_out && !read_strobe_pin_out && !byte_enable_pin_out
		&& address_pins_out == 16'h0000 && data_pins_oe_n_out && !busy_out)
		else $error("port active while disabled");
	write_gate_a: assert property (!ctl_ff[9] && !$past(ctl_ff[9]) |->
		!write_strobe_pin_out) else $error("write strobe pin not released");
	read_gate_a: assert property (!ctl_ff[8] && !$past(ctl_ff[8]) |->
		!read_strobe_pin_out) else $error("read strobe pin not released");
	busy_rise_a: assert property (start && mst && !busy_out |=> busy_out)
		else $error("busy missing after start");
	busy_cause_a: assert property ($rose(busy_out) |->
		$past(reg_addr_in) == ppt_pkg::ADDR_DATA && ($past(reg_write_in) || $past(reg_read_in)))
		else $error("busy without a data access");
	slave_idle_a: assert property (!mode_ff[9] && !$past(mode_ff[9]) |-> !busy_out)
		else $error("busy in slave mode");
	pin_owner_a: assert property (((address_pin_func_out & ~(pen_ff | $past(pen_ff)))
		& ppt_pkg::PIN_EN_MASK) == 16'h0000)
		else $error("pin owned without enable");
	pin_io_a: assert property ((address_pins_out & ~address_pin_func_out) == 16'h0000)
		else $error("address on an I/O pin");
	in_all_a: assert property (st_q_ff && !mode_ff[9] |->
		reg_rdata_out[15] == &reg_rdata_out[11:8]) else $error("input all-full wrong");
	out_all_a: assert property (st_q_ff && !mode_ff[9] |->
		reg_rdata_out[7] == &reg_rdata_out[3:0]) else $error("output all-empty wrong");
endmodule
bind ppt_port ppt_port_monitor mon (.*);
`default_nettype wire

// >>> ppt_port_tb_top.sv
// Purpose: Self-checking bench for the parallel port
// Assumes: Register port with read data one cycle after the strobe
// Notes:   Peer model plays external master and peripheral
`timescale 1ns/1ps
`default_nettype none
module ppt_port_tb_top;
	logic        clock_in = 1'b0;
	logic        rst_in = 1'b1;
	logic [2:0]  reg_addr_in = 3'h0;
	logic [15:0] reg_wdata_in = 16'h0000;
	logic        reg_write_in = 1'b0;
	logic        reg_read_in = 1'b0;
	logic [15:0] reg_rdata_out, address_pins_out, address_pin_func_out;
	logic [7:0]  data_pins_in, data_pins_out;
	logic        data_pins_oe_n_out, write_strobe_pin_out, read_strobe_pin_out;
	logic        byte_enable_pin_out, ext_write_in, ext_read_in, ext_cs_in;
	logic [1:0]  ext_addr_in;
	logic        busy_out, ttl_select_out;
	logic        read_strobe_polarity = 1'b0;
	int          fails = 0;
	int          check_count = 0;
	logic [2:0]  ri [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5};
	logic [15:0] rm [5] = '{ppt_pkg::CONTROL_MASK, 16'h7FFF, 16'hFFFF,
		ppt_pkg::PIN_EN_MASK, ppt_pkg::PADCFG_MASK};
	always #5 clock_in = ~clock_in;
	ppt_port dut (.*);
	ppt_peer_model peer (.clock_in(clock_in), .rd_strobe_in(read_strobe_pin_out),
		.rd_pol_in(read_strobe_polarity), .reply_in(8'h3C), .data_out(data_pins_in), .wr_out(ext_write_in),
		.rd_out(ext_read_in), .cs_out(ext_cs_in), .slot_out(ext_addr_in));
	task automatic cmp16(input logic [15:0] got, input logic [15:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge clock_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_write_in <= 1'b1;
		@(posedge clock_in);
		reg_write_in <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, output logic [15:0] d);
		@(posedge clock_in);
		reg_addr_in <= a;
		reg_read_in <= 1'b1;
		@(posedge clock_in);
		reg_read_in <= 1'b0;
		#1 d = reg_rdata_out;
	endtask
	task automatic chk(input logic [2:0] a, input logic [15:0] e);
		logic [15:0] d;
		rd(a, d);
		cmp16(d, e, "register read");
	endtask
	// One master cycle; counts busy cycles, active strobe cycles and bad pins
	task automatic mxfer(input logic wrt, input logic [7:0] v, input logic pol,
		input logic cs, input logic [15:0] a, output int bc, output int sc, output int bad);
		logic [15:0] dummy;
		bc = 0;
		sc = 0;
		bad = 0;
		if (wrt) wr(3'h6, {8'h00, v});
		else rd(3'h6, dummy);
		for (int k = 0; k < 40; k++) begin
			#1;
			if (busy_out === 1'b1) bc++;
			else if (bc > 0) break;
			if ((wrt ? write_strobe_pin_out : read_strobe_pin_out) === pol) begin
				sc++;
				if (address_pins_out[14:0] !== {cs, 3'h0, a[10:0]}) bad++;
				if (wrt && {data_pins_out, data_pins_oe_n_out} !== {v, 1'b0}) bad++;
			end
			@(posedge clock_in);
		end
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge clock_in);
		fails++;
		$display("wrong value at %0t: run did not finish", $time);
		conclude;
	end
	initial begin
		logic [15:0] d;
		logic [3:0]  m;
		int          bc, sc, bad;
		repeat (12) @(posedge clock_in);
		rst_in <= 1'b0;
		for (int a = 0; a < 8; a++) chk(a[2:0], a == 4 ? 16'h008F : 16'h0000);
		$display("test reset values done");
		for (int i = 0; i < 5; i++) wr(ri[i], 16'hFFFF);
		for (int i = 0; i < 5; i++) chk(ri[i], rm[i]);
		cmp16({15'h0000, ttl_select_out}, 16'h0001, "input buffer select");
		for (int i = 0; i < 5; i++) wr(ri[i], 16'h0000);
		$display("test register access done");
		wr(3'h0, 16'h8000);
		for (int k = 0; k < 4; k++) peer.access(1'b1, 2'h0, 8'(8'h11 * (k + 1)));
		chk(3'h4, 16'h8F8F);
		for (int k = 0; k < 4; k++) begin
			wr(3'h2, 16'(k));
			chk(3'h6, 16'(16'h0011 * (k + 1)));
			if (k == 0) chk(3'h4, 16'h0E8F);
		end
		chk(3'h4, 16'h008F);
		wr(3'h1, 16'h0100);
		peer.access(1'b1, 2'h2, 8'h21);
		peer.access(1'b1, 2'h2, 8'h22);
		chk(3'h4, 16'h448F);
		peer.access(1'b0, 2'h1, 8'h00);
		chk(3'h4, 16'h44CF);
		wr(3'h2, 16'h0001);
		wr(3'h6, 16'h005A);
		chk(3'h4, 16'h444D);
		wr(3'h4, 16'h0000);
		chk(3'h4, 16'h040D);
		peer.access(1'b0, 2'h1, 8'h00);
		chk(3'h4, 16'h048F);
		$display("test slave buffers done");
		for (int i = 0; i < 4; i++) begin
			m = 4'(i * 2);
			wr(3'h1, {5'h01, 1'b0, i[1] ? 2'h3 : 2'h2, 2'h1, m, 2'h2});
			wr(3'h3, 16'h47FF);
			wr(3'h2, 16'h4000 | 16'(i));
			wr(3'h0, i[0] ? 16'h838B : 16'h8380);
			mxfer(1'b1, 8'hA0 + 8'(i), i[0], i[0], 16'(i), bc, sc, bad);
			cmp16(16'(sc), 16'(m + 1), "strobe cycles");
			cmp16(16'(bc), m == 0 ? 16'h0001 : 16'(m + 6), "busy cycles");
			cmp16(16'(bad), 16'h0000, "pins in strobe");
			chk(3'h2, 16'h4001 + 16'(i));
		end
		$display("test master writes done");
		read_strobe_polarity = 1'b1;
		wr(3'h1, 16'h0240);
		wr(3'h2, 16'h4000);
		wr(3'h0, 16'h8381);
		mxfer(1'b0, 8'h00, 1'b1, 1'b0, 16'h0000, bc, sc, bad);
		cmp16(16'(sc), 16'h0001, "read strobe cycles");
		cmp16(16'(bad), 16'h0000, "address in read");
		rd(3'h6, d);
		cmp16(d, 16'h003C, "master read data");
		for (int k = 0; k < 40 && busy_out !== 1'b0; k++) @(posedge clock_in);
		$display("test master read done");
		wr(3'h1, 16'h1200);
		wr(3'h2, 16'h4004);
		wr(3'h0, 16'h8BA0);
		mxfer(1'b1, 8'h5C, 1'b0, 1'b0, 16'h0004, bc, sc, bad);
		cmp16(16'(bc), 16'h0002, "muxed busy cycles");
		cmp16(16'(sc), 16'h0001, "muxed strobe cycles");
		cmp16(16'(bad), 16'h0000, "muxed pins in strobe");
		chk(3'h2, 16'h4003);
		$display("test muxed master write done");
		wr(3'h0, 16'h0000);
		wr(3'h6, 16'h00FF);
		repeat (3) @(posedge clock_in);
		#1;
		cmp16(address_pins_out, 16'h0000, "address while off");
		cmp16({11'h000, busy_out, write_strobe_pin_out, read_strobe_pin_out,
			byte_enable_pin_out, data_pins_oe_n_out}, 16'h0001, "pins while off");
		$display("test disabled port done");
		conclude;
	end
endmodule
`default_nettype wire
